// file: vpit_defs.svh
// constants for the vectored priority interrupt table
// Behaviour
// RULE1: higher level always served before lower level
// RULE2: same level: lowest vector number wins
// RULE3: entry address is vector base plus offset
// RULE4: offset is twice the vector number
// RULE5: entry addresses limited to nineteen bits; the code makes 21-bit addresses and checks only the offset
// RULE6: reset is slot 0, watchdog reset slot 1
// RULE7: software puts jumps in slots 0-1, calls elsewhere
// RULE8: vectors 2 to 5 fixed at level 3
// RULE9: debug vectors 6 to 10 take level 1-3
// RULE10: software assigns levels to ranged sources
// RULE11: vectors 15 and 16 take level 1-3
// RULE12: vectors 17 to 62 take level 0-2
// RULE13: vector 63 lowest, served only when alone
// RULE14: winner's entry address presented to core
// RULE15: reset base makes slots overlay reset addresses
`ifndef VPIT_DEFS_SVH
`define VPIT_DEFS_SVH
`define VPIT_NUM_VEC      64
`define VPIT_VEC_W        6
`define VPIT_ADDR_W       21
`define VPIT_REACH_W      19
`define VPIT_BASE_W       13
`define VPIT_BASE_SHIFT   8
`define VPIT_BASE_RESET   13'h0000
`define VPIT_RESET_VEC    6'h00
`define VPIT_WDOG_VEC     6'h01
`define VPIT_FIX3_LO      6'h02
`define VPIT_FIX3_HI      6'h05
`define VPIT_DBG_LO       6'h06
`define VPIT_DBG_HI       6'h0A
`define VPIT_SW2_VEC      6'h0B
`define VPIT_SW1_VEC      6'h0C
`define VPIT_SW0_VEC      6'h0D
`define VPIT_RSVD_VEC     6'h0E
`define VPIT_LV_LO        6'h0F
`define VPIT_LV_HI        6'h10
`define VPIT_PER_LO       6'h11
`define VPIT_PER_HI       6'h3E
`define VPIT_SWLP_VEC     6'h3F
`endif

// file: vpit_pkg.sv
// types for the vectored priority interrupt table
package vpit_pkg;
	// encoded level: 0 none, 1 = level -1, 2..5 = levels 0..3
	typedef logic [2:0] vpit_rank_type;
	typedef logic [1:0] vpit_level_type;
	typedef enum logic [1:0]
	{
		VPIT_IDLE = 2'b01,
		VPIT_HOLD = 2'b10
	} vpit_state_type;
endpackage

// file: vpit_rank.sv
// per-source rank: effective level after clamping to the allowed range
`timescale 1ns/1ps
`include "vpit_defs.svh"
module vpit_rank
#(
	parameter logic [5:0] VEC = 6'h00
)
(
	input  wire logic                    i_req,
	input  wire vpit_pkg::vpit_level_type i_level,
	output      vpit_pkg::vpit_rank_type  o_rank
);
	wire logic [1:0] fixed_lvl;
	wire logic [1:0] clamp13;
	wire logic [1:0] clamp02;
	wire logic [1:0] eff_lvl;
	wire logic       is_swlp;
	wire logic       is_none;

	assign clamp13 = (i_level == 2'h0) ? 2'h1 : i_level;                         // [RULE9] [RULE11]
	assign clamp02 = (i_level == 2'h3) ? 2'h2 : i_level;                         // [RULE12]
	assign fixed_lvl = (VEC == `VPIT_SW2_VEC) ? 2'h2 :
	                   (VEC == `VPIT_SW1_VEC) ? 2'h1 :
	                   (VEC == `VPIT_SW0_VEC) ? 2'h0 : 2'h3;                    // [RULE8]
	assign eff_lvl = ((VEC >= `VPIT_DBG_LO) && (VEC <= `VPIT_DBG_HI)) ? clamp13 :
	                 ((VEC >= `VPIT_LV_LO) && (VEC <= `VPIT_LV_HI)) ? clamp13 :
	                 ((VEC >= `VPIT_PER_LO) && (VEC <= `VPIT_PER_HI)) ? clamp02 :
	                 fixed_lvl;                                                  // [RULE10]
	assign is_swlp = (VEC == `VPIT_SWLP_VEC);
	assign is_none = (VEC < `VPIT_FIX3_LO) || (VEC == `VPIT_RSVD_VEC);           // [RULE6]
	assign o_rank = (!i_req || is_none) ? 3'h0 :
	                is_swlp ? 3'h1 :                                             // [RULE13]
	                (3'h2 + {1'b0, eff_lvl});
endmodule

// file: vpit_core.sv
// priority resolver and vector address generator
`timescale 1ns/1ps
`include "vpit_defs.svh"
module vpit_core
(
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_b,
	input  wire logic [`VPIT_NUM_VEC-1:0]  i_req,
	input  wire logic [2*`VPIT_NUM_VEC-1:0] i_level,
	input  wire logic [`VPIT_BASE_W-1:0]   i_vector_base,
	input  wire logic                      i_base_load,
	input  wire logic                      i_ack,
	output      logic                      o_irq,
	output      logic [`VPIT_VEC_W-1:0]    o_vector,
	output      logic [1:0]                o_level,
	output      logic [`VPIT_ADDR_W-1:0]   o_fetch_addr,
	output      logic [`VPIT_ADDR_W-1:0]   o_reset_addr,
	output      logic [`VPIT_ADDR_W-1:0]   o_wdog_addr
);
	// ****************************************
	// per-source rank
	// ****************************************
	vpit_pkg::vpit_rank_type rank [`VPIT_NUM_VEC];
	logic [`VPIT_BASE_W-1:0] vector_base;
	vpit_pkg::vpit_state_type state;
	vpit_pkg::vpit_state_type next_state;

	genvar g;
	generate
		for (g = 0; g < `VPIT_NUM_VEC; g++)
		begin : g_src
			vpit_rank
			#(
				.VEC (6'(g))
			)
			u_rank
			(
				.i_req   (i_req[g]),
				.i_level (i_level[2*g +: 2]),
				.o_rank  (rank[g])
			);
		end
	endgenerate

	// ****************************************
	// selection
	// ****************************************
	function automatic logic [`VPIT_ADDR_W-1:0] entry_addr(input logic [`VPIT_BASE_W-1:0] base,
		input logic [`VPIT_VEC_W-1:0] vec);
		logic [`VPIT_ADDR_W-1:0] b;
		b = {base, 8'h00};                                                    // [RULE3]
		entry_addr = b + {14'h0000, vec, 1'b0};                               // [RULE4]
	endfunction

	vpit_pkg::vpit_rank_type  best_rank;
	logic [`VPIT_VEC_W-1:0]   best_vec;
	always_comb
	begin
		best_rank = 3'h0;
		best_vec  = 6'h00;
		// strictly greater keeps the lowest vector on a tie
		for (int i = 0; i < `VPIT_NUM_VEC; i++)
		begin
			if (rank[i] > best_rank)                                          // [RULE1] [RULE2]
			begin
				best_rank = rank[i];
				best_vec  = 6'(i);
			end
		end
	end

	wire logic win_valid;
	wire logic [1:0] win_level;
	assign win_valid = (best_rank != 3'h0);
	assign win_level = (best_rank >= 3'h2) ? 2'(best_rank - 3'h2) : 2'h0;

	// ****************************************
	// base register and handshake
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			vector_base <= `VPIT_BASE_RESET;                                  // [RULE15]
		else if (i_base_load)
			vector_base <= i_vector_base;
	end

	always_comb
	begin
		next_state = state;
		unique case (state)
			vpit_pkg::VPIT_IDLE:
			begin
				if (win_valid)
					next_state = vpit_pkg::VPIT_HOLD;
			end
			vpit_pkg::VPIT_HOLD:
			begin
				if (i_ack)
					next_state = vpit_pkg::VPIT_IDLE;
			end
			default: next_state = vpit_pkg::VPIT_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state        <= vpit_pkg::VPIT_IDLE;
			o_vector     <= 6'h00;
			o_level      <= 2'h0;
			o_fetch_addr <= 21'h00_0000;
		end
		else
		begin
			state <= next_state;
			if (state == vpit_pkg::VPIT_IDLE && win_valid)
			begin
				o_vector     <= best_vec;
				o_level      <= win_level;
				o_fetch_addr <= entry_addr(vector_base, best_vec);            // [RULE14]
			end
		end
	end

	assign o_irq = (state == vpit_pkg::VPIT_HOLD);
	// entry points of chip reset and watchdog reset, overlaid on slots 0 and 1
	assign o_reset_addr = entry_addr(vector_base, `VPIT_RESET_VEC);            // [RULE6]
	assign o_wdog_addr  = entry_addr(vector_base, `VPIT_WDOG_VEC);             // [RULE6]

	// ****************************************
	// checks
	// ****************************************
	// the address was formed from the base as it stood at the take edge
	fetch_addr_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE4]
		$rose(o_irq) |-> o_fetch_addr == {$past(vector_base), 8'h00} + {14'h0000, o_vector, 1'b0})
		else $error("fetch address not base plus twice vector");
	fixed_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE8]
		$rose(o_irq) && o_vector >= 6'h02 && o_vector <= 6'h05 |-> o_level == 2'h3)
		else $error("core exception not at level 3");
	per_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE12]
		$rose(o_irq) && o_vector >= 6'h11 && o_vector <= 6'h3E |-> o_level <= 2'h2)
		else $error("peripheral above level 2");
	dbg_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE9]
		$rose(o_irq) && (o_vector inside {[6'h06:6'h0A], 6'h0F, 6'h10}) |-> o_level != 2'h0)
		else $error("ranged source at level 0");
	swlp_alone_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE13]
		state == vpit_pkg::VPIT_IDLE && win_valid && best_vec == 6'h3F
		|-> (i_req[62:2] & ~(61'h1 << 12)) == 61'h0)
		else $error("low priority chosen with others pending");
	swlp_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE13]
		$rose(o_irq) && o_vector == 6'h3F |-> o_level == 2'h0)
		else $error("low priority shown above level 0");
	sw_fixed_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE8]
		$rose(o_irq) && (o_vector inside {6'h0B, 6'h0C, 6'h0D}) |-> o_level == 2'(6'h0D - o_vector))
		else $error("software interrupt at wrong fixed level");
	no_slot01_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE6]
		o_irq |-> o_vector > 6'h01)
		else $error("reset slot delivered as interrupt");
	hold_ack_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE14]
		o_irq && !i_ack |=> o_irq && $stable(o_vector))
		else $error("request dropped before acknowledge");
	ack_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE14]
		o_irq && i_ack |=> !o_irq)
		else $error("interrupt held after acknowledge");
	take_next_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE14]
		state == vpit_pkg::VPIT_IDLE && win_valid |=> o_irq)
		else $error("pending winner not raised");
	top_pri_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE1] [RULE2]
		state == vpit_pkg::VPIT_IDLE && i_req[2] |=> o_vector == 6'h02)
		else $error("vector 2 not winner");
	reach_limit_a: assert property (@(posedge i_clk) disable iff (!i_rst_b) // [RULE5]
		$rose(o_irq) |-> o_fetch_addr - {$past(vector_base), 8'h00} < 21'h08_0000)
		else $error("entry offset beyond reach");
endmodule

// file: vpit_core_model.sv
// processor core model that acknowledges vectored interrupts
`timescale 1ns/1ps
module vpit_core_model
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_irq,
	input  wire logic [3:0] i_wait,
	output      logic       o_ack
);
	logic [3:0] count;
	// ****
	// one ack per raised interrupt
	// ****
	// ack stands for one rising edge only, so it is never seen twice
	always @(negedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_ack <= 1'b0;
			count <= 4'h0;
		end
		else if (o_ack || !i_irq)
		begin
			o_ack <= 1'b0;
			count <= 4'h0;
		end
		else if (count >= i_wait)
			o_ack <= 1'b1;
		else
			count <= count + 4'h1;
	end
endmodule

// file: vectored_priority_interrupt_table_bench.sv
// self-checking bench for the vectored priority interrupt table
`timescale 1ns/1ps
module vectored_priority_interrupt_table_bench;
	logic         clk = 1'b0;
	logic         rst_b = 1'b0;
	logic [63:0]  req = '0;
	logic [127:0] lvl = '0;
	logic [12:0]  base = '0;
	logic         load = 1'b0;
	logic [3:0]   wt = 4'h0;
	logic         ack, irq;
	logic [5:0]   vec;
	logic [1:0]   olvl;
	logic [20:0]  fetch, radr, cadr;
	logic [63:0]  call_slot = ~64'h3; // jumps in slots 0-1, calls in every other slot
	int           n_errors = 0;
	int           checked = 0;
	always #10 clk = ~clk;
	vpit_core u_vpit_core (.i_clk(clk), .i_rst_b(rst_b), .i_req(req), .i_level(lvl), .i_vector_base(base),
		.i_base_load(load), .i_ack(ack), .o_irq(irq), .o_vector(vec), .o_level(olvl), .o_fetch_addr(fetch),
		.o_reset_addr(radr), .o_wdog_addr(cadr));
	vpit_core_model u_vpit_core_model (.i_clk(clk), .i_rst_b(rst_b), .i_irq(irq), .i_wait(wt), .o_ack(ack));
	task automatic results;
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [20:0] got, input logic [20:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic setl(input int v, input logic [1:0] l);
		lvl[2*v +: 2] = l;
	endtask
	// wait for the interrupt, judge it, drop its request, wait for release
	task automatic serve(input int v, input logic [1:0] l);
		int i;
		for (i = 0; i < 30 && irq !== 1'b1; i++)
			@(negedge clk);
		chk(irq, 21'h0_0001);
		chk(vec, v[5:0]);
		chk(olvl, l);
		chk(fetch, {base, 8'h00} + 21'(2 * v));
		chk(21'(call_slot[vec]), 21'h0_0001);
		req[v] = 1'b0;
		for (i = 0; i < 30 && irq !== 1'b0; i++)
			@(negedge clk);
		chk(irq, 21'h0_0000);
	endtask
	task automatic quiet;
		repeat (6) @(negedge clk);
		chk(irq, 21'h0_0000);
	endtask
	// ****
	// scenarios
	// ****
	task automatic mixed_levels;
		setl(20, 2'h2);
		setl(17, 2'h0);
		setl(6, 2'h1);
		req = (64'h1 << 63) | (64'h1 << 20) | (64'h1 << 17) | (64'h1 << 6) | (64'h1 << 2);
		serve(2, 2'h3);
		serve(20, 2'h2);
		serve(6, 2'h1);
		serve(17, 2'h0);
		serve(63, 2'h0);
		quiet();
	endtask
	task automatic same_level;
		wt = 4'h5;
		setl(30, 2'h1);
		setl(25, 2'h1);
		req = (64'h1 << 30) | (64'h1 << 25) | (64'h1 << 14) | 64'h3;
		serve(25, 2'h1);
		serve(30, 2'h1);
		quiet();
		req = '0;
		wt = 4'h0;
	endtask
	task automatic clamped;
		setl(16, 2'h3);
		setl(15, 2'h0);
		setl(40, 2'h3);
		setl(9, 2'h0);
		req = (64'h1 << 40) | (64'h1 << 16) | (64'h1 << 15) | (64'h1 << 9);
		serve(16, 2'h3);
		serve(40, 2'h2);
		serve(9, 2'h1);
		serve(15, 2'h1);
	endtask
	// levels written for fixed sources must be ignored
	task automatic fixed_levels;
		setl(3, 2'h0);
		setl(5, 2'h0);
		setl(7, 2'h3);
		setl(11, 2'h0);
		setl(12, 2'h3);
		setl(13, 2'h3);
		req = (64'h1 << 13) | (64'h1 << 12) | (64'h1 << 11) | (64'h1 << 7) | (64'h1 << 5) | (64'h1 << 3);
		serve(3, 2'h3);
		serve(5, 2'h3);
		serve(7, 2'h3);
		serve(11, 2'h2);
		serve(12, 2'h1);
		serve(13, 2'h0);
	endtask
	// reset while an interrupt is held, after the base was moved
	task automatic reset_again;
		wt = 4'hf;
		req[40] = 1'b1;
		repeat (2) @(negedge clk);
		chk(irq, 21'h0_0001);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		chk(irq, 21'h0_0000);
		chk(vec, 21'h0_0000);
		chk(olvl, 21'h0_0000);
		chk(fetch, 21'h0_0000);
		chk(radr, 21'h0_0000);
		chk(cadr, 21'h0_0002);
		req[40] = 1'b0;
		wt = 4'h0;
		rst_b = 1'b1;
		quiet();
	endtask
	task automatic moved_base;
		base = 13'h1abc;
		load = 1'b1;
		@(negedge clk);
		load = 1'b0;
		@(negedge clk);
		chk(radr, {base, 8'h00});
		chk(cadr, {base, 8'h02});
		setl(62, 2'h2);
		req[62] = 1'b1;
		serve(62, 2'h2);
	endtask
	initial
	begin
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		chk(radr, 21'h0_0000);
		chk(cadr, 21'h0_0002);
		mixed_levels();
		same_level();
		clamped();
		fixed_levels();
		moved_base();
		reset_again();
		results();
	end
	initial
	begin
		#200_000;
		n_errors++;
		results();
	end
endmodule
